// ---- core/pac_pkg.sv ----
package pac_pkg;

    // Data path widths and channel count
    localparam int DW    = 16;
    localparam int EW    = 18;
    localparam int NCH   = 2;
    localparam int KW    = 4;
    localparam int DLYW  = 10;
    localparam int AW    = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TARGET   = 8'h04;
    localparam logic [7:0] OFS_MEASURED = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_CH_BASE  = 8'h20;
    localparam logic [7:0] OFS_CH_STEP  = 8'h10;
    localparam logic [3:0] OFS_CH_KIND  = 4'h0;
    localparam logic [3:0] OFS_CH_HIGH  = 4'h4;
    localparam logic [3:0] OFS_CH_LOW   = 4'h8;
    localparam logic [3:0] OFS_CH_DELAY = 4'hC;

    // Field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_REARM_BIT = 1;
    localparam int STAT_OUT_LSB   = 4;
    localparam int IRQ_FALL_LSB   = 2;
    localparam int DLY_ON_LSB     = 0;
    localparam int DLY_OFF_LSB    = 16;

    // Reset values
    localparam logic            CTRL_EN_RST = 1'b1;
    localparam logic [KW-1:0]   KIND_RST    = 4'h2;
    localparam logic [DW-1:0]   VALUE_RST   = 16'h0000;
    localparam logic [DLYW-1:0] DLY_RST     = 10'h000;
    localparam logic [3:0]      IRQ_RST     = 4'h0;

    // Timing: delays count whole seconds of a 125 MHz clock
    localparam longint CLK_PERIOD_NS = 8;
    localparam longint SEC_NS        = 1000000000;
    localparam int     SEC_CYC       = int'(SEC_NS / CLK_PERIOD_NS);

    // Alarm type codes
    typedef enum logic [3:0] {
        PAC_OFF         = 4'h0,
        PAC_DEV_BOTH    = 4'h1,
        PAC_DEV_UP      = 4'h2,
        PAC_DEV_DOWN    = 4'h3,
        PAC_DEV_BAND    = 4'h4,
        PAC_DEV_BOTH_SB = 4'h5,
        PAC_DEV_UP_SB   = 4'h6,
        PAC_DEV_DOWN_SB = 4'h7,
        PAC_ABS_UP      = 4'h8,
        PAC_ABS_DOWN    = 4'h9,
        PAC_ABS_UP_SB   = 4'hA,
        PAC_ABS_DOWN_SB = 4'hB
    } pac_kind_t;

    // Per-channel configuration
    typedef struct packed {
        logic [KW-1:0]          kind;
        logic signed [DW-1:0]   high;
        logic signed [DW-1:0]   low;
        logic [DLYW-1:0]        on_dly;
        logic [DLYW-1:0]        off_dly;
    } pac_cfg_t;

endpackage : pac_pkg

// ---- core/pac_alarm_eval.sv ----
`timescale 1ns/1ns
module pac_alarm_eval
    import pac_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 sample_i,
    input  wire logic signed [DW-1:0] measured_i,
    input  wire logic signed [DW-1:0] target_i,
    input  wire pac_cfg_t             cfg_i,
    input  wire logic                 rearm_i,
    output logic                      cond_o
);

    logic signed [EW-1:0] mv;
    logic signed [EW-1:0] upper;
    logic signed [EW-1:0] lower;
    logic signed [EW-1:0] xv;
    logic                 raw;
    logic                 standby_type;
    logic                 armed_reg;

    // Widen to avoid overflow of target plus deviation
    assign mv    = EW'(measured_i);
    assign xv    = EW'(cfg_i.high);
    assign upper = EW'(target_i) + EW'(cfg_i.high);
    assign lower = EW'(target_i) - EW'(cfg_i.low);

    // Raw comparison per type code
    always_comb begin
        raw          = 1'b0;
        standby_type = 1'b0;
        case (cfg_i.kind)
            PAC_OFF:         raw = 1'b0;                                 // R15
            PAC_DEV_BOTH:    raw = (mv > upper) || (mv < lower);         // R1
            PAC_DEV_UP:      raw = (mv >= upper);                        // R2 R3
            PAC_DEV_DOWN:    raw = (mv <= EW'(target_i) - xv);           // R4
            PAC_DEV_BAND:    raw = (mv >= lower) && (mv <= upper);       // R5
            PAC_DEV_BOTH_SB: begin
                raw          = (mv > upper) || (mv < lower);             // R6
                standby_type = 1'b1;
            end
            PAC_DEV_UP_SB:   begin
                raw          = (mv >= upper);                            // R7
                standby_type = 1'b1;
            end
            PAC_DEV_DOWN_SB: begin
                raw          = (mv <= EW'(target_i) - xv);               // R8
                standby_type = 1'b1;
            end
            PAC_ABS_UP:      raw = (mv > xv);                            // R9
            PAC_ABS_DOWN:    raw = (mv < xv);                            // R10
            PAC_ABS_UP_SB:   begin
                raw          = (mv > xv);                                // R11
                standby_type = 1'b1;
            end
            PAC_ABS_DOWN_SB: begin
                raw          = (mv < xv);                                // R12
                standby_type = 1'b1;
            end
            default:         raw = 1'b0;
        endcase
    end

    // Standby latch: armed at start-up and on re-arm, released once condition clears
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            armed_reg <= 1'b1;
        end else if (rearm_i) begin
            armed_reg <= 1'b1;                                           // R16
        end else if (sample_i && !raw) begin
            armed_reg <= 1'b0;                                           // R16
        end
    end

    // Condition updated once per sample
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cond_o <= 1'b0;
        end else if (rearm_i && standby_type) begin
            cond_o <= 1'b0;
        end else if (sample_i) begin
            cond_o <= raw && !(standby_type && armed_reg);               // R17 R16
        end
    end

endmodule : pac_alarm_eval

// ---- core/pac_process_alarm.sv ----
`timescale 1ns/1ns
// How it works
// R1: Type 1 alarms when the measured value is above target plus high deviation or below target minus low deviation.
// R2: Type 2, the reset default, alarms when the measured value is at or above target plus the alarm value.
// R3: In type 2 the single alarm value is an upward deviation from the current target.
// R4: Type 3 alarms when the measured value is at or below target minus the alarm value.
// R5: Type 4 alarms while the measured value lies inside target minus low to target plus high.
// R6: Type 5 is type 1 with standby suppression.
// R7: Type 6 is type 2 with standby suppression.
// R8: Type 7 is type 3 with standby suppression.
// R9: Type 8 alarms when the measured value is greater than the alarm value, target ignored.
// R10: Type 9 alarms when the measured value is less than the alarm value, target ignored.
// R11: Type 10 is type 8 with standby suppression.
// R12: Type 11 is type 9 with standby suppression.
// R13: Each channel keeps its own type setting.
// R14: Each alarm output has its own on and off delay of 0 to 999 seconds.
// R15: Type 0 keeps the alarm off.
// R16: Standby holds the alarm off after start-up or a target change until the condition has first cleared.
// R17: Every comparison is re-evaluated once per sample in signed arithmetic.
module pac_process_alarm
    import pac_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYC
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [AW-1:0]        paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic                 sample_i,
    input  wire logic signed [DW-1:0] measured_value_i,
    output logic      [NCH-1:0]       alarm_o,
    output logic                      irq_o
);

    localparam logic [DLYW-1:0] DLY_MAX = 10'h3E7;

    logic                 en_reg;
    logic signed [DW-1:0] target_point_reg;
    logic signed [DW-1:0] measured_value_reg;
    pac_cfg_t             cfg_reg [NCH];
    logic [3:0]           irq_stat_reg;
    logic [3:0]           irq_mask_reg;
    logic [31:0]          rdata_reg;
    logic                 err_reg;
    logic [31:0]          sec_cnt_reg;
    logic                 sec_tick;
    logic [NCH-1:0]       cond;
    logic [NCH-1:0]       out_reg;
    logic [DLYW-1:0]      dly_cnt_reg [NCH];
    logic [NCH-1:0]       rearm;
    logic [NCH-1:0]       rise;
    logic [NCH-1:0]       fall;
    logic                 setup;
    logic                 wr;
    logic                 ch_hit;
    logic [0:0]           ch_idx;
    logic [3:0]           ch_ofs;
    logic                 mapped;
    logic                 target_wr;
    logic                 rearm_wr;

    // Zero-wait slave: data is prepared in the setup cycle
    assign pready_o  = 1'b1;
    assign prdata_o  = rdata_reg;
    assign pslverr_o = psel_i && penable_i && err_reg;

    assign setup = psel_i && !penable_i;
    assign wr    = psel_i && penable_i && pwrite_i && !err_reg;

    // Channel window decode
    always_comb begin
        ch_hit = 1'b0;
        ch_idx = 1'b0;
        ch_ofs = paddr_i[3:0];
        if (paddr_i >= OFS_CH_BASE && paddr_i < OFS_CH_BASE + 8'(NCH * OFS_CH_STEP)) begin
            ch_hit = (paddr_i[1:0] == 2'h0);
            ch_idx = 1'(paddr_i[7:4] - OFS_CH_BASE[7:4]);
        end
    end

    // Address map check
    always_comb begin
        case (paddr_i)
            OFS_CTRL, OFS_TARGET, OFS_MEASURED,
            OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
            default:                                mapped = ch_hit;
        endcase
    end

    // Error flag latched for the access phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            err_reg <= 1'b0;
        end else if (setup) begin
            err_reg <= !mapped;
        end
    end

    // Read data captured in setup
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite_i) begin
            rdata_reg <= 32'h0000_0000;
            case (paddr_i)
                OFS_CTRL:     rdata_reg[CTRL_EN_BIT] <= en_reg;
                OFS_TARGET:   rdata_reg <= 32'(signed'(target_point_reg));
                OFS_MEASURED: rdata_reg <= 32'(signed'(measured_value_reg));
                OFS_STATUS:   rdata_reg <= {24'h00_0000, 2'h0, out_reg, 2'h0, cond};
                OFS_IRQ_STAT: rdata_reg <= {28'h000_0000, irq_stat_reg};
                OFS_IRQ_MASK: rdata_reg <= {28'h000_0000, irq_mask_reg};
                default: begin
                    if (ch_hit) begin
                        case (ch_ofs)
                            OFS_CH_KIND:  rdata_reg <= {28'h000_0000, cfg_reg[ch_idx].kind};
                            OFS_CH_HIGH:  rdata_reg <= 32'(signed'(cfg_reg[ch_idx].high));
                            OFS_CH_LOW:   rdata_reg <= 32'(signed'(cfg_reg[ch_idx].low));
                            OFS_CH_DELAY: rdata_reg <= {6'h00, cfg_reg[ch_idx].off_dly,
                                                        6'h00, cfg_reg[ch_idx].on_dly};
                            default:      rdata_reg <= 32'h0000_0000;
                        endcase
                    end
                end
            endcase
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            en_reg <= CTRL_EN_RST;
        end else if (wr && paddr_i == OFS_CTRL) begin
            en_reg <= pwdata_i[CTRL_EN_BIT];
        end
    end

    assign target_wr = wr && (paddr_i == OFS_TARGET);
    assign rearm_wr  = wr && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_REARM_BIT];

    // Target point
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            target_point_reg <= VALUE_RST;
        end else if (target_wr) begin
            target_point_reg <= pwdata_i[DW-1:0];
        end
    end

    // Last sampled measured value, readable by software
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            measured_value_reg <= VALUE_RST;
        end else if (sample_i) begin
            measured_value_reg <= measured_value_i;
        end
    end

    // Per-channel configuration, delays clamped to the allowed maximum
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_reg[i].kind    <= KIND_RST;                          // R2
                cfg_reg[i].high    <= VALUE_RST;
                cfg_reg[i].low     <= VALUE_RST;
                cfg_reg[i].on_dly  <= DLY_RST;
                cfg_reg[i].off_dly <= DLY_RST;
            end
        end else if (wr && ch_hit) begin
            case (ch_ofs)
                OFS_CH_KIND:  cfg_reg[ch_idx].kind <= pwdata_i[KW-1:0];  // R13
                OFS_CH_HIGH:  cfg_reg[ch_idx].high <= pwdata_i[DW-1:0];
                OFS_CH_LOW:   cfg_reg[ch_idx].low  <= pwdata_i[DW-1:0];
                OFS_CH_DELAY: begin
                    cfg_reg[ch_idx].on_dly  <= (pwdata_i[DLY_ON_LSB +: DLYW] > DLY_MAX) ?
                                               DLY_MAX : pwdata_i[DLY_ON_LSB +: DLYW];     // R14
                    cfg_reg[ch_idx].off_dly <= (pwdata_i[DLY_OFF_LSB +: DLYW] > DLY_MAX) ?
                                               DLY_MAX : pwdata_i[DLY_OFF_LSB +: DLYW];   // R14
                end
                default: ;
            endcase
        end
    end

    // One-second enable pulse
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sec_cnt_reg <= 32'h0000_0000;
        end else if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
            sec_cnt_reg <= 32'h0000_0000;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
        end
    end

    assign sec_tick = (sec_cnt_reg == 32'(SEC_CYCLES - 1));

    // Standby re-armed by target change, type change or software request
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rearm[i] = target_wr || rearm_wr ||
                       (wr && ch_hit && ch_idx == 1'(i) && ch_ofs == OFS_CH_KIND);     // R16
        end
    end

    // One evaluator per channel
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        pac_alarm_eval u_eval (
            .clk_i      (clk_i),
            .rst_n_i    (rst_n_i),
            .sample_i   (sample_i),
            .measured_i (measured_value_i),
            .target_i   (target_point_reg),
            .cfg_i      (cfg_reg[g]),
            .rearm_i    (rearm[g]),
            .cond_o     (cond[g])
        );
    end

    // On and off delay timers per output
    // A nonzero delay waits one tick more, so a setting of n lasts n to n+1 s and never less
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NCH; i++) begin
                out_reg[i]     <= 1'b0;
                dly_cnt_reg[i] <= DLY_RST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!en_reg || cfg_reg[i].kind == PAC_OFF) begin
                    out_reg[i]     <= 1'b0;                              // R15
                    dly_cnt_reg[i] <= DLY_RST;
                end else if (cond[i] == out_reg[i]) begin
                    dly_cnt_reg[i] <= DLY_RST;
                end else if (cond[i] && (cfg_reg[i].on_dly == 10'h000 || dly_cnt_reg[i] > cfg_reg[i].on_dly)) begin
                    out_reg[i]     <= 1'b1;                              // R14
                    dly_cnt_reg[i] <= DLY_RST;
                end else if (!cond[i] && (cfg_reg[i].off_dly == 10'h000 || dly_cnt_reg[i] > cfg_reg[i].off_dly)) begin
                    out_reg[i]     <= 1'b0;                              // R14
                    dly_cnt_reg[i] <= DLY_RST;
                end else if (sec_tick) begin
                    dly_cnt_reg[i] <= dly_cnt_reg[i] + 10'h001;
                end
            end
        end
    end

    assign alarm_o = out_reg;

    // Output edge events
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rise[i] = 1'b0;
            fall[i] = 1'b0;
        end
        for (int i = 0; i < NCH; i++) begin
            if (en_reg && cfg_reg[i].kind != PAC_OFF && cond[i] != out_reg[i]) begin
                rise[i] = cond[i] && (cfg_reg[i].on_dly == 10'h000 || dly_cnt_reg[i] > cfg_reg[i].on_dly);
                fall[i] = !cond[i] && (cfg_reg[i].off_dly == 10'h000 || dly_cnt_reg[i] > cfg_reg[i].off_dly);
            end
        end
    end

    // Sticky status, write one to clear, a new event wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat_reg <= IRQ_RST;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr && paddr_i == OFS_IRQ_STAT) ? pwdata_i[3:0] : 4'h0))
                            | {fall, rise};
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_mask_reg <= IRQ_RST;
        end else if (wr && paddr_i == OFS_IRQ_MASK) begin
            irq_mask_reg <= pwdata_i[3:0];
        end
    end

    // Level interrupt
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((irq_stat_reg & ~((wr && paddr_i == OFS_IRQ_STAT) ? pwdata_i[3:0] : 4'h0)
                       | {fall, rise}) & irq_mask_reg);
        end
    end

endmodule : pac_process_alarm

// ---- test/pac_meas_model.sv ----
`timescale 1ns/1ns
module pac_meas_model
    import pac_pkg::*;
(
    input  wire logic            clk_i,
    output logic                 sample_o,
    output logic signed [DW-1:0] value_o
);
    // Quiet front end at time zero
    initial begin
        sample_o = 1'b0;
        value_o  = 16'h0000;
    end

    // One sample pulse after gap idle cycles; the bus is scrambled outside it
    task automatic send(input logic signed [DW-1:0] v, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        sample_o <= 1'b1;
        value_o  <= v;
        @(posedge clk_i);
        sample_o <= 1'b0;
        value_o  <= ~v; // Stale value must never be taken
    endtask : send
endmodule : pac_meas_model

// ---- test/pac_process_alarm_asserts.sv ----
`timescale 1ns/1ns
module pac_process_alarm_asserts
    import pac_pkg::*;
(
    input wire logic           clk_i,
    input wire logic           rst_n_i,
    input wire logic           psel_i,
    input wire logic           penable_i,
    input wire logic           pwrite_i,
    input wire logic [AW-1:0]  paddr_i,
    input wire logic [31:0]    prdata_o,
    input wire logic           pready_o,
    input wire logic           pslverr_o,
    input wire logic [NCH-1:0] alarm_o,
    input wire logic           irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Bus phase and address class decode
    logic acc;
    logic wr;
    logic bad;
    logic good;
    assign acc  = psel_i && penable_i;
    assign wr   = acc && pwrite_i;
    assign bad  = paddr_i >= 8'h40 || paddr_i == 8'h18 || paddr_i == 8'h1C;
    assign good = (paddr_i <= 8'h14 || paddr_i[7:5] == 3'b001) && paddr_i[1:0] == 2'b00;

    chk_ready_high: assert property (pready_o) else $error("pready low");
    chk_err_access: assert property (pslverr_o |-> acc) else $error("pslverr outside access");
    chk_err_unmapped: assert property (acc && bad |-> pslverr_o) else $error("unmapped not refused");
    chk_ok_mapped: assert property (acc && !pwrite_i && good |-> !pslverr_o) else $error("mapped read refused");
    chk_rd_zero: assert property (acc && !pwrite_i && bad |-> prdata_o == 32'h0) else $error("unmapped read not 0");
    chk_reset_quiet: assert property ($rose(rst_n_i) |-> alarm_o == 2'b00 && !irq_o)
        else $error("outputs not quiet after reset");
    chk_prdata_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
        else $error("read data moved without read");
    chk_irq_rise: assert property ($rose(irq_o) |-> alarm_o != $past(alarm_o) || $past(wr) || $past(wr, 2))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(irq_o) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt fell without write");
endmodule : pac_process_alarm_asserts

bind pac_process_alarm pac_process_alarm_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .alarm_o(alarm_o), .irq_o(irq_o));

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import pac_pkg::*;
    logic                 clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic                 sample_i, irq_o, se, sb, e;
    logic [AW-1:0]        paddr_i;
    logic [31:0]          pwdata_i, prdata_o, rd;
    logic signed [DW-1:0] measured_value_i;
    logic [NCH-1:0]       alarm_o;
    int                   errors, n_tests, k, i;
    int                   tgt = 100, hh = 20, ll = 10;
    int                   pvs[9] = '{125, 120, 105, 90, 85, 80, 20, 15, -300};

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    pac_process_alarm #(.SEC_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample_i),
        .measured_value_i(measured_value_i), .alarm_o(alarm_o), .irq_o(irq_o));

    pac_meas_model u_meas (.clk_i(clk_i), .sample_o(sample_i), .value_o(measured_value_i));

    task automatic report_and_stop;
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            report_and_stop();
        end
        rd = prdata_o;
        se = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    // Sample and let condition and zero-delay alarm settle
    task automatic smp(input int v);
        u_meas.send(16'(v), 1);
        repeat (3) @(posedge clk_i);
    endtask : smp

    // Count settled cycles until channel 0 alarm reaches v
    task automatic wait_al(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (alarm_o[0] !== v && n < 100);
        if (n >= 100) begin
            errors++;
            report_and_stop();
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask : wait_al

    // Raw alarm condition of channel 0 before standby
    function automatic logic raw(input int t, input int p);
        case (t)
            1, 5:    return p > tgt + hh || p < tgt - ll;
            2, 6:    return p >= tgt + hh;
            3, 7:    return p <= tgt - hh;
            4:       return p >= tgt - ll && p <= tgt + hh;
            8, 10:   return p > hh;
            9, 11:   return p < hh;
            default: return 1'b0;
        endcase
    endfunction : raw

    // Main sequence
    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        errors  = 0;
        n_tests = 0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(OFS_CTRL, 32'h1);
        rdc(OFS_TARGET, 32'h0);
        rdc(8'h20, 32'h2);
        rdc(8'h30, 32'h2);
        rdc(OFS_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(se), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_TARGET, 32'h64);
        apb(1'b1, 8'h24, 32'h14);
        apb(1'b1, 8'h28, 32'h0A);
        for (k = 0; k < 13; k++) begin
            apb(1'b1, 8'h20, 32'(k));
            sb = 1'b1;
            for (i = 0; i < 9; i++) begin
                smp(pvs[i]);
                e = raw(k, pvs[i]);
                if (!e) sb = 1'b0;
                e = e && !(sb && k inside {5, 6, 7, 10, 11});
                chk({30'h0, alarm_o}, {30'h0, pvs[i] >= 100, e});
            end
        end
        apb(1'b1, OFS_MEASURED, 32'h1234);
        rdc(OFS_MEASURED, 32'hFFFF_FED4);
        apb(1'b1, 8'h20, 32'h8);
        apb(1'b1, 8'h2C, 32'h0001_0002);
        smp(50);
        wait_al(1'b1, 20, 30);
        smp(0);
        wait_al(1'b0, 10, 20);
        apb(1'b1, 8'h2C, 32'h0);
        apb(1'b1, 8'h30, 32'h0);
        apb(1'b1, OFS_IRQ_STAT, 32'hF);
        rdc(OFS_IRQ_STAT, 32'h0);
        smp(50);
        rdc(OFS_IRQ_STAT, 32'h1);
        rdc(OFS_STATUS, 32'h11);
        chk({31'h0, irq_o}, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h5);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        smp(0);
        rdc(OFS_IRQ_STAT, 32'h5);
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        apb(1'b1, 8'h20, 32'hA);
        smp(0);
        smp(50);
        chk({30'h0, alarm_o}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h3);
        smp(50);
        chk({30'h0, alarm_o}, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0);
        smp(50);
        chk({30'h0, alarm_o}, 32'h0);
        report_and_stop();
    end
endmodule : tb_top
